// ==== design/pdct_defines.svh ====
// Offsets, field positions, reset values and timing counts of the timer.
// Included by the timer; holds definitions only.
`ifndef PDCT_DEFINES_SVH
`define PDCT_DEFINES_SVH
// ----------------------------------------
// Register offsets (byte index on the plain port)
// ----------------------------------------
`define PDCT_OFF_CTL0 8'h00
`define PDCT_OFF_CTL1 8'h01
`define PDCT_OFF_CNTH 8'h02
`define PDCT_OFF_CNTL 8'h03
`define PDCT_OFF_RLDH 8'h04
`define PDCT_OFF_RLDL 8'h05
`define PDCT_OFF_PWMH 8'h06
`define PDCT_OFF_PWML 8'h07
`define PDCT_OFF_DBND 8'h08
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PDCT_CTL1_EN 7
`define PDCT_CTL1_POL 6
`define PDCT_CTL1_PRE_LO 3
`define PDCT_CTL1_MODE_LO 0
`define PDCT_CTL0_MODEHI 7
`define PDCT_CTL0_ICFG_LO 5
`define PDCT_CTL0_CAPF 4
`define PDCT_CTL0_OUTEN 0
// ----------------------------------------
// Values and reset values
// ----------------------------------------
`define PDCT_COUNT_RESTART 16'h0001
`define PDCT_COUNT_RESET 16'h0001
`define PDCT_RELOAD_RESET 16'hFFFF
`define PDCT_CAP_CLEAR 16'h0000
`define PDCT_DBND_MAX 8'h80
`endif

// ==== design/pdct_pkg.sv ====
// Types shared by the PWM and capture timer.
// Assumes pdct_defines.svh sits on the include path.
package pdct_pkg;
  // Mode code: {mode_select_high, mode_select_low}
  typedef enum logic [3:0] {
    PDCT_MODE_PWM_SINGLE = 4'h3,
    PDCT_MODE_CAPTURE = 4'h4,
    PDCT_MODE_PWM_DUAL = 4'h8
  } pdct_mode_t;
  // Interrupt source selection
  typedef enum logic [1:0] {
    PDCT_ICFG_BOTH = 2'h0,
    PDCT_ICFG_BOTH_ALT = 2'h1,
    PDCT_ICFG_CAPTURE = 2'h2,
    PDCT_ICFG_RELOAD = 2'h3
  } pdct_icfg_t;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pdct_bus_req_t;
  // Pin group of the timer
  typedef struct packed {
    logic out;
    logic out_en;
    logic comp;
    logic comp_en;
  } pdct_pins_t;
endpackage

// ==== design/pdct_timer.sv ====
// PWM single/dual output and capture timer with a plain register port.
// Assumes one 10 MHz clock; the timer input pin is asynchronous.
//
// Operation
// - PWM start count used once, then 0001H
// - Counter ticks on prescaled clock to reload
// - Count equal match toggles the output
// - Reload raises interrupt, restarts at 0001H
// - Polarity sets start, match and reload levels
// - Dual mode drives complement of output
// - Dual mode rising edges delayed by deadband cycles, at most 80H
// - Dual mode turns input pin into complement
// - Mode from both mode select fields
// - Capture counter runs on prescaled clock
// - Selected input edge copies count to PWM
// - Capture raises interrupt, sets cause flag
// - Capture reload raises interrupt, clears flag
// - Interrupt source config picks capture/reload
// - Output driven only with alternate enabled
`timescale 1ns/1ps
`include "pdct_defines.svh"
module pdct_timer #(
  parameter int PRE_W = 3 // Prescale field width, divide 2^n
) (
  input wire logic i_sys_clk, // System clock 10 MHz
  input wire logic i_resetn, // Async reset, active low
  input wire pdct_pkg::pdct_bus_req_t i_bus, // Register request
  output logic [7:0] o_rdata, // Read data, cycle after read
  input wire logic i_tin, // Timer input pin level
  output logic o_tout, // Timer output level
  output logic o_tout_oe, // Timer output enable
  output logic o_tcomp, // Complement output level
  output logic o_tcomp_oe, // Complement output enable
  output logic o_irq // Timer interrupt pulse
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ctl0_q, ctl1_q, dbnd_q; // Control and deadband
  logic [15:0] cnt_q, rld_q, pwm_q; // Count, reload, match/capture
  logic [7:0] pre_q; // Prescale divider
  logic pwm_lvl_q; // Raw PWM level
  logic [7:0] dly_q, dlyc_q; // Deadband counters
  logic [2:0] tin_q; // Input synchroniser
  logic tin_old_q; // Last agreed input level
  logic capf_q; // Capture cause flag
  logic [7:0] rd_q; // Read data
  logic tout_q, tcomp_q, touten_q, tcompen_q, irq_q;
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire en = ctl1_q[`PDCT_CTL1_EN];
  wire pol = ctl1_q[`PDCT_CTL1_POL];
  wire [3:0] mode = {ctl0_q[`PDCT_CTL0_MODEHI],
                     ctl1_q[`PDCT_CTL1_MODE_LO +: 3]};
  wire is_dual = mode == pdct_pkg::PDCT_MODE_PWM_DUAL;
  wire is_pwm = is_dual || mode == pdct_pkg::PDCT_MODE_PWM_SINGLE;
  wire is_cap = mode == pdct_pkg::PDCT_MODE_CAPTURE;
  wire [1:0] icfg = ctl0_q[`PDCT_CTL0_ICFG_LO +: 2];
  wire [PRE_W-1:0] pre_sel = ctl1_q[`PDCT_CTL1_PRE_LO +: PRE_W];
  wire [7:0] pre_lim = 8'((9'h1 << pre_sel) - 9'h1);
  // Tick once per prescaled period
  wire tick = en && (pre_q == pre_lim);
  wire at_rld = tick && (cnt_q == rld_q);
  wire at_match = tick && is_pwm && (cnt_q == pwm_q) && !at_rld;
  // Input edge once second and third stages agree and differ from old
  wire agreed = tin_q[1] == tin_q[2];
  wire edge_ok = agreed && (tin_q[2] != tin_old_q);
  wire cap_ev = en && is_cap && edge_ok &&
                (tin_q[2] == !pol);
  wire wr = i_bus.wr;
  wire [7:0] a = i_bus.addr;
  wire [7:0] w = i_bus.wdata;
  wire irq_cap = cap_ev && icfg != pdct_pkg::PDCT_ICFG_RELOAD;
  wire irq_rld = at_rld && (!is_cap ||
                 icfg != pdct_pkg::PDCT_ICFG_CAPTURE);
  // Deadband: active-going edges wait dbnd cycles
  wire [7:0] dbnd = (dbnd_q > `PDCT_DBND_MAX) ? `PDCT_DBND_MAX : dbnd_q;
  wire p_act = pwm_lvl_q;
  wire c_act = !pwm_lvl_q;
  wire p_go = p_act && (dbnd == 8'h00 || dly_q >= dbnd);
  wire c_go = c_act && (dbnd == 8'h00 || dlyc_q >= dbnd);
  wire out_en = ctl0_q[`PDCT_CTL0_OUTEN];
  // ----------------------------------------
  // Control registers and read port
  // ----------------------------------------
  // Software writes; hardware owns flag bit in ctl0
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl0_q <= 8'h00;
      ctl1_q <= 8'h00;
      dbnd_q <= 8'h00;
      rld_q <= `PDCT_RELOAD_RESET;
    end else if (wr) begin
      if (a == `PDCT_OFF_CTL0) ctl0_q <= w;
      if (a == `PDCT_OFF_CTL1) ctl1_q <= w;
      if (a == `PDCT_OFF_DBND) dbnd_q <= w;
      if (a == `PDCT_OFF_RLDH) rld_q[15:8] <= w;
      if (a == `PDCT_OFF_RLDL) rld_q[7:0] <= w;
    end
  end
  // Read mux; unmapped offsets read zero
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) rd_q <= 8'h00;
    else if (!i_bus.rd) rd_q <= 8'h00;
    else begin
      case (a)
        `PDCT_OFF_CTL0: rd_q <= {ctl0_q[7:5], capf_q, ctl0_q[3:0]};
        `PDCT_OFF_CTL1: rd_q <= ctl1_q;
        `PDCT_OFF_CNTH: rd_q <= cnt_q[15:8];
        `PDCT_OFF_CNTL: rd_q <= cnt_q[7:0];
        `PDCT_OFF_RLDH: rd_q <= rld_q[15:8];
        `PDCT_OFF_RLDL: rd_q <= rld_q[7:0];
        `PDCT_OFF_PWMH: rd_q <= pwm_q[15:8];
        `PDCT_OFF_PWML: rd_q <= pwm_q[7:0];
        `PDCT_OFF_DBND: rd_q <= dbnd_q;
        default: rd_q <= 8'h00;
      endcase
    end
  end
  // ----------------------------------------
  // Counter and prescaler
  // ----------------------------------------
  // Software count write applies at any time, wins over reload and tick, and sets the first pass only
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= `PDCT_COUNT_RESET;
      pre_q <= 8'h00;
    end else begin
      pre_q <= (!en || tick) ? 8'h00 : pre_q + 8'h01;
      if (wr && a == `PDCT_OFF_CNTH) cnt_q[15:8] <= w;
      else if (wr && a == `PDCT_OFF_CNTL) cnt_q[7:0] <= w;
      else if (at_rld) cnt_q <= `PDCT_COUNT_RESTART;
      else if (tick) cnt_q <= cnt_q + 16'h0001;
    end
  end
  // Match/capture register: software value or captured count
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) pwm_q <= `PDCT_CAP_CLEAR;
    else if (cap_ev) pwm_q <= cnt_q;
    else if (wr && a == `PDCT_OFF_PWMH) pwm_q[15:8] <= w;
    else if (wr && a == `PDCT_OFF_PWML) pwm_q[7:0] <= w;
  end
  // ----------------------------------------
  // Input synchroniser and capture flag
  // ----------------------------------------
  // Three stages; stage 1 only feeds stage 2
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tin_q <= 3'h0;
      tin_old_q <= 1'b0;
      capf_q <= 1'b0;
    end else begin
      tin_q <= {tin_q[1:0], i_tin};
      if (agreed) tin_old_q <= tin_q[2];
      if (cap_ev) capf_q <= 1'b1;
      else if (at_rld && is_cap) capf_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // PWM level and deadband
  // ----------------------------------------
  // Raw level: pol=1 starts high, low at match, high at reload
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) pwm_lvl_q <= 1'b0;
    else if (!en || !is_pwm) pwm_lvl_q <= pol;
    else if (at_rld) pwm_lvl_q <= pol;
    else if (at_match) pwm_lvl_q <= !pwm_lvl_q;
  end
  // Count cycles each output has been wanting to go active
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dly_q <= 8'h00;
      dlyc_q <= 8'h00;
    end else begin
      dly_q <= (!p_act || !en) ? 8'h00 :
               (dly_q == 8'hFF ? dly_q : dly_q + 8'h01);
      dlyc_q <= (!c_act || !en) ? 8'h00 :
                (dlyc_q == 8'hFF ? dlyc_q : dlyc_q + 8'h01);
    end
  end
  // ----------------------------------------
  // Pin outputs and interrupt
  // ----------------------------------------
  // Single mode has no deadband; falling edges are immediate
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tout_q <= 1'b0;
      tcomp_q <= 1'b0;
      touten_q <= 1'b0;
      tcompen_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      tout_q <= en && is_pwm && (is_dual ? p_go : pwm_lvl_q);
      tcomp_q <= en && is_dual && c_go;
      touten_q <= out_en && (is_pwm || !en);
      tcompen_q <= out_en && is_dual;
      irq_q <= irq_cap || irq_rld;
    end
  end
  assign o_rdata = rd_q;
  assign o_tout = tout_q;
  assign o_tout_oe = touten_q;
  assign o_tcomp = tcomp_q;
  assign o_tcomp_oe = tcompen_q;
  assign o_irq = irq_q;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // All checks sample on the system clock and sleep during reset
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // Counter and interrupt
  // A count write in the reload cycle wins, so it excuses the restart
  chk_reload_restart: assert property (
    at_rld |=> cnt_q == `PDCT_COUNT_RESTART || $past(wr))
    else $error("count not restarted at reload");
  // Between reloads each tick adds exactly one
  chk_tick_step: assert property (
    tick && !at_rld && !wr |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("count did not step by one");
  // With a divider the cycle after a tick never ticks again
  chk_prescale_gap: assert property (
    tick && pre_lim != 8'h00 && !wr |=> !tick)
    else $error("prescaler ticked twice in a row");
  // Outside capture mode every reload pulses the interrupt
  chk_reload_irq: assert property (
    at_rld && !is_cap |=> o_irq)
    else $error("no interrupt at reload");
  // Raw PWM level
  // Match flips the raw level unless a reload took the same tick
  chk_match_toggle: assert property (
    at_match && !$past(at_rld) |=> pwm_lvl_q != $past(pwm_lvl_q))
    else $error("no toggle");
  // Reload puts the raw level back to the polarity start level
  chk_reload_level: assert property (
    at_rld && is_pwm |=> pwm_lvl_q == $past(pol))
    else $error("level not restored at reload");
  // While stopped the raw level waits at the start level
  chk_idle_level: assert property (
    !en |=> pwm_lvl_q == $past(pol))
    else $error("start level wrong while stopped");
  // Dual outputs and pins
  // With no deadband the complement is the exact inverse
  chk_comp_mirror: assert property (
    en && is_dual && dbnd == 8'h00 |=> o_tcomp != o_tout)
    else $error("complement not inverse of output");
  // A rising raw level is held back while the deadband runs
  chk_dead_delay: assert property (
    en && is_dual && $rose(p_act) && dbnd != 8'h00 |=> !o_tout)
    else $error("rising edge not delayed");
  // Falling edges must never wait, or the pair would overlap
  chk_fall_fast: assert property (
    is_dual && !p_act |=> !o_tout)
    else $error("falling edge delayed");
  // Never both pins active at once in dual mode
  chk_no_overlap: assert property (
    !(o_tout && o_tcomp && is_dual))
    else $error("both outputs active");
  // Dual mode claims the shared input pin for the complement
  chk_comp_enable: assert property (
    is_dual && out_en |=> o_tcomp_oe)
    else $error("complement pin not enabled");
  // A stopped timer leaves both outputs inactive
  chk_idle_inactive: assert property (
    !en |=> !o_tout && !o_tcomp)
    else $error("output active while disabled");
  // Pins stay undriven unless the alternate function is on
  chk_pin_enable: assert property (
    !out_en |=> !o_tout_oe && !o_tcomp_oe)
    else $error("pin driven without alternate enable");
  // Capture
  // Capture takes the count of the edge cycle
  chk_capture_copy: assert property (
    cap_ev |=> pwm_q == $past(cnt_q))
    else $error("capture value wrong");
  // Only a capture or a write may change the match register
  chk_capture_hold: assert property (
    !cap_ev && !wr |=> pwm_q == $past(pwm_q))
    else $error("match register changed on its own");
  // Every capture marks itself as the interrupt cause
  chk_capture_flag: assert property (
    cap_ev |=> capf_q)
    else $error("cause flag not set");
  // Captures interrupt unless reload-only is selected
  chk_capture_irq: assert property (
    cap_ev && icfg != pdct_pkg::PDCT_ICFG_RELOAD |=> o_irq)
    else $error("no interrupt at capture");
  // In capture mode a reload without a capture clears the cause flag
  chk_reload_flag: assert property (
    at_rld && is_cap && !cap_ev |=> !capf_q)
    else $error("cause flag not cleared");
  // In capture mode, capture-only selection silences reload interrupts
  chk_capture_only: assert property (
    at_rld && is_cap && !cap_ev &&
    icfg == pdct_pkg::PDCT_ICFG_CAPTURE |=> !o_irq)
    else $error("reload interrupt not suppressed");
  // Scenarios that the bench should reach
  cov_reload: cover property (at_rld && is_pwm);
  cov_capture: cover property (cap_ev);
  cov_dual_comp: cover property (is_dual && o_tcomp);
  cov_dead_delay: cover property (
    is_dual && dbnd != 8'h00 && $rose(o_tout));
endmodule

// ==== sim/pdct_pin_model.sv ====
// Far side of the timer pins: a signal source on the shared input pin.
// Assumes the timer owns that pin whenever its complement output is on.
`timescale 1ns/1ps
module pdct_pin_model (
  input wire logic i_src, // Level the external source wants
  input wire logic i_comp, // Complement output of the timer
  input wire logic i_comp_oe, // Complement output enable
  output logic o_pin // Resolved pin level back to the timer
);
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  // Source backs off while the timer drives, so the two never fight
  assign o_pin = i_comp_oe ? i_comp : i_src;
endmodule

// ==== sim/pdct_timer_tb.sv ====
// Self-checking bench for the PWM and capture timer.
// Assumes the design files and the pin model are compiled first.
`timescale 1ns/1ps
module pdct_timer_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic i_sys_clk = 1'b0; // 10 MHz clock
  logic i_resetn = 1'b0; // Reset, active low
  pdct_pkg::pdct_bus_req_t bus = '0; // Register request
  logic [7:0] rdata; // Read data
  logic tout, tout_oe, tcomp, tcomp_oe, irq, pin; // Pins
  logic src = 1'b0; // Source level on the input pin
  int err_count = 0; // Mismatches
  int check_count = 0; // Comparisons
  int cyc = 0; // Cycles, for the hang guard
  int n, ht, hc, hb; // Period, high times, overlap
  logic [15:0] v; // Read-back value
  always #50 i_sys_clk = ~i_sys_clk;
  pdct_timer i_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_bus(bus), .o_rdata(rdata), .i_tin(pin), .o_tout(tout),
    .o_tout_oe(tout_oe), .o_tcomp(tcomp), .o_tcomp_oe(tcomp_oe),
    .o_irq(irq));
  pdct_pin_model i_pin (.i_src(src), .i_comp(tcomp),
    .i_comp_oe(tcomp_oe), .o_pin(pin));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got,
        exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    bus <= {a, d, 2'h2};
    @(posedge i_sys_clk);
    bus <= '0;
  endtask
  // Data stand only in the cycle after the strobe, so sample just then
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    bus <= {a, 8'h00, 2'h1};
    @(posedge i_sys_clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic rd16(input logic [7:0] a);
    rd(a, v[15:8]);
    rd(a + 8'h01, v[7:0]);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] x);
    wr(a, x[15:8]);
    wr(a + 8'h01, x[7:0]);
  endtask
  // Timer is stopped before anything else is touched
  task automatic cfg(input logic [7:0] c0, c1, input logic [15:0] ct,
    pw, rl, input logic [7:0] db);
    wr(8'h01, c1 & 8'h7F);
    wr(8'h00, c0);
    wr16(8'h02, ct);
    wr16(8'h06, pw);
    wr16(8'h04, rl);
    wr(8'h08, db);
    wr(8'h01, c1);
  endtask
  // Bounded wait for an interrupt pulse; n is lim if none came
  task automatic wirq(input int lim);
    n = 0;
    do begin
      @(posedge i_sys_clk);
      #1 n++;
    end while (irq !== 1'b1 && n < lim);
  endtask
  // One full period with high times of both outputs and their overlap
  task automatic per();
    n = 0;
    ht = 0;
    hc = 0;
    hb = 0;
    do begin
      @(posedge i_sys_clk);
      #1 n++;
      ht += (tout === 1'b1);
      hc += (tcomp === 1'b1);
      hb += (tout === 1'b1 && tcomp === 1'b1);
    end while (irq !== 1'b1 && n < 3000);
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    chk(32'(tout | tcomp | irq), 32'h0);
    rd16(8'h02);
    chk(v, 32'h0001);
    rd16(8'h04);
    chk(v, 32'hFFFF);
    rd(8'h20, v[7:0]);
    chk(v[7:0], 32'h00);
    // Single output: two polarities, then divide by 2 with pin off
    for (int i = 0; i < 3; i++) begin
      cfg({7'h00, !i[1]}, {1'b1, i[0], 2'h0, i[1], 3'h3}, 16'h0008,
        16'h0003, 16'h000A, 8'h00);
      wirq(3000);
      chk(32'(n < (9 << i[1])), 32'h1);
      per();
      chk(n, 10 << i[1]);
      chk(ht, (i[0] ? 3 : 7) << i[1]);
      chk(32'(tout_oe), 32'(!i[1]));
    end
    // Dual output without and with a deadband
    for (int d = 0; d < 4; d += 2) begin
      cfg(8'h81, 8'h80, 16'h0001, 16'h0006, 16'h0010, 8'(d));
      wirq(3000);
      per();
      chk(n, 16);
      chk(ht, 10 - d);
      chk(hc, 6 - d);
      chk(hb, 0);
      chk(32'(tcomp_oe), 32'h1);
      chk(32'(pin), 32'(tcomp));
    end
    wr(8'h01, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    #1 chk(32'(tout | tcomp), 32'h0);
    // Capture on a rising edge, then a reload with the counter running
    cfg(8'h01, 8'h84, 16'h0001, 16'h0000, 16'h0100, 8'h00);
    repeat (20) @(posedge i_sys_clk);
    src <= 1'b1;
    wirq(10);
    chk(32'(n < 10), 32'h1);
    rd16(8'h06);
    chk(32'(v > 16'h0014 && v < 16'h001D), 32'h1);
    rd(8'h00, v[7:0]);
    chk(32'(v[4]), 32'h1);
    wirq(400);
    chk(32'(n > 200 && n < 245), 32'h1);
    // Period is timed from the reload pulse itself, flag read after
    per();
    chk(n, 256);
    rd(8'h00, v[7:0]);
    chk(32'(v[4]), 32'h0);
    // Capture only, falling edge: reloads stay quiet
    cfg(8'h41, 8'hC4, 16'h0001, 16'h0000, 16'h0100, 8'h00);
    repeat (5) @(posedge i_sys_clk);
    src <= 1'b0;
    wirq(10);
    chk(32'(n < 10), 32'h1);
    wirq(600);
    chk(n, 600);
    // Reload only: a capture stays quiet, the reload does not
    cfg(8'h61, 8'h84, 16'h0001, 16'h0000, 16'h0100, 8'h00);
    repeat (5) @(posedge i_sys_clk);
    src <= 1'b1;
    wirq(200);
    chk(n, 200);
    wirq(100);
    chk(32'(n < 100), 32'h1);
    report_and_stop();
  end
endmodule
